// *** core/cpu_regs_pkg.sv ***
// Behaviour
// - Eight identical 32-bit general registers
// - Each register splits into two 16-bit halves
// - Lower half splits into high, low bytes
// - Register seven doubles as stack pointer
// - 24-bit program counter, fetch LSB zero
// - Condition code bit order I UI H U N Z V C
// - Mask bit blocks all but non-maskable interrupt
// - Exception entry sets interrupt mask bit
// - Bit six read/write by condition ops
// - Bit four user bit, no hardware effect
// - Byte ops: half-carry from bit 3
// - Word ops: half-carry from bit 11
// - Longword ops: half-carry from bit 27
// - Negative flag follows result sign bit
// - Zero flag set on zero result
// - Overflow flag set on arithmetic overflow
// - Carry: carry, borrow, shift-out, bit accumulator
// - Some ops keep flags; NZVC feed branches
// - Reset loads vector PC, sets mask bit
// - 1-Mbyte modes drop upper four address bits (busAddr only here; fetchAddr keeps them)
// - Bit ops select bit 0-7; BCD nibbles
// - Odd word/long addresses force LSB zero
package cpu_regs_pkg;
  // ==========================================================
  // Widths
  localparam int DataWidth = 32;
  localparam int PcWidth = 24;
  localparam int CcWidth = 8;
  localparam int ShortAddrWidth = 20;
  localparam int StackIndex = 7;
  // ==========================================================
  // condition code bit positions
  localparam int CcMaskBit = 7;
  localparam int CcUserMaskBit = 6;
  localparam int CcHalfBit = 5;
  localparam int CcUserBit = 4;
  localparam int CcNegBit = 3;
  localparam int CcZeroBit = 2;
  localparam int CcOvfBit = 1;
  localparam int CcCarryBit = 0;
  // Half-carry source bits per operand size
  localparam int HalfByteBit = 3;
  localparam int HalfWordBit = 11;
  localparam int HalfLongBit = 27;
  // ==========================================================
  // Access views of a general register
  typedef enum logic [2:0] {
    VIEW_LONG = 3'b000,
    VIEW_EXT = 3'b001,
    VIEW_LOW16 = 3'b010,
    VIEW_HIGH_BYTE = 3'b011,
    VIEW_LOW_BYTE = 3'b100
  } view_t;
  // Operand size of a flag-producing operation
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_WORD = 2'b01,
    SIZE_LONG = 2'b10
  } size_t;
  // Flag update classes
  typedef enum logic [2:0] {
    FLAG_KEEP = 3'b000,
    FLAG_ADD = 3'b001,
    FLAG_SUB = 3'b010,
    FLAG_LOGIC = 3'b011,
    FLAG_SHIFT = 3'b100,
    FLAG_BITACC = 3'b101
  } flag_op_t;
  // Condition-code instruction kinds
  typedef enum logic [2:0] {
    CC_NONE = 3'b000,
    CC_LOAD = 3'b001,
    CC_AND = 3'b010,
    CC_OR = 3'b011,
    CC_XOR = 3'b100
  } cc_op_t;
  // Branch conditions
  typedef enum logic [3:0] {
    BR_ALWAYS = 4'h0, BR_NEVER = 4'h1, BR_HI = 4'h2, BR_LS = 4'h3,
    BR_CC = 4'h4, BR_CS = 4'h5, BR_NE = 4'h6, BR_EQ = 4'h7,
    BR_VC = 4'h8, BR_VS = 4'h9, BR_PL = 4'ha, BR_MI = 4'hb,
    BR_GE = 4'hc, BR_LT = 4'hd, BR_GT = 4'he, BR_LE = 4'hf
  } branch_t;
  localparam logic [7:0] CcMaskSet = 8'h80;
endpackage : cpu_regs_pkg

// *** core/cpu_flag_unit.sv ***
`timescale 1ns/10ps
`default_nettype none
// Combinational flag computation for one ALU result
module cpu_flag_unit
  import cpu_regs_pkg::*;
(
  input wire logic [DataWidth-1:0] opA, // First operand
  input wire logic [DataWidth-1:0] opB, // Second operand (as applied)
  input wire logic [DataWidth-1:0] result, // ALU result
  input wire size_t opSize, // Operand size
  input wire flag_op_t flagOp, // Flag update class
  input wire logic shiftOut, // Bit shifted out
  input wire logic bitAcc, // New bit accumulator value
  input wire logic [3:0] flagsIn, // Current N Z V C
  input wire logic halfIn, // Current half-carry
  output logic [3:0] flagsOut, // New N Z V C
  output logic halfOut // New half-carry
);
  // ==========================================================
  // Size-dependent sign, zero, and carry positions
  logic signR, signA, signB, isZero, carryOut, halfCarry;
  logic [DataWidth:0] sumFull;
  logic [DataWidth:0] subFull;
  logic [28:0] halfSum;
  logic [28:0] halfSub;
  int msb;
  int hb;

  // Flag computation
  always_comb
  begin
    msb = (opSize == SIZE_BYTE) ? 7 : (opSize == SIZE_WORD) ? 15 : 31;
    hb = (opSize == SIZE_BYTE) ? HalfByteBit :
         (opSize == SIZE_WORD) ? HalfWordBit : HalfLongBit;
    signR = result[msb];
    signA = opA[msb];
    signB = opB[msb];
    case (opSize)
      SIZE_BYTE: isZero = (result[7:0] == 8'h00);
      SIZE_WORD: isZero = (result[15:0] == 16'h0000);
      default: isZero = (result == 32'h0000_0000);
    endcase
    sumFull = {1'b0, opA} + {1'b0, opB};
    subFull = {1'b0, opA} - {1'b0, opB};
    // Carry at bit boundary uses masked low parts
    case (opSize)
      SIZE_BYTE: carryOut = (flagOp == FLAG_ADD) ?
        (({1'b0, opA[7:0]} + {1'b0, opB[7:0]}) >> 8) != 9'h000 :
        (opA[7:0] < opB[7:0]);
      SIZE_WORD: carryOut = (flagOp == FLAG_ADD) ?
        (({1'b0, opA[15:0]} + {1'b0, opB[15:0]}) >> 16) != 17'h00000 :
        (opA[15:0] < opB[15:0]);
      default: carryOut = (flagOp == FLAG_ADD) ? sumFull[DataWidth] :
        subFull[DataWidth];
    endcase
    // half carry from bit 3, 11 or 27
    halfSum = {1'b0, opA[27:0]} + {1'b0, opB[27:0]};
    halfSub = {1'b0, opA[27:0]} - {1'b0, opB[27:0]};
    case (hb)
      HalfByteBit: halfCarry = (flagOp == FLAG_ADD) ?
        (opA[3:0] + opB[3:0]) > 5'h0f : (opA[3:0] < opB[3:0]);
      HalfWordBit: halfCarry = (flagOp == FLAG_ADD) ?
        ({1'b0, opA[11:0]} + {1'b0, opB[11:0]}) > 13'h0fff :
        (opA[11:0] < opB[11:0]);
      default: halfCarry = (flagOp == FLAG_ADD) ? halfSum[28] : halfSub[28];
    endcase
    flagsOut = flagsIn;
    halfOut = halfIn;
    case (flagOp)
      FLAG_ADD:
      begin
        flagsOut = {signR, isZero, (signA == signB) && (signR != signA),
                    carryOut};
        halfOut = halfCarry;
      end
      FLAG_SUB:
      begin
        flagsOut = {signR, isZero, (signA != signB) && (signR != signA),
                    carryOut};
        halfOut = halfCarry;
      end
      FLAG_LOGIC:
        flagsOut = {signR, isZero, 1'b0, flagsIn[0]};
      FLAG_SHIFT:
        flagsOut = {signR, isZero, 1'b0, shiftOut};
      FLAG_BITACC:
        flagsOut = {flagsIn[3:1], bitAcc};
      default:
        flagsOut = flagsIn;
    endcase
  end
endmodule : cpu_flag_unit
`default_nettype wire

// *** core/cpu_register_file_ccr.sv ***
`timescale 1ns/10ps
`default_nettype none
// Programmer-visible CPU register state
module cpu_register_file_ccr
  import cpu_regs_pkg::*;
#(
  parameter int NumRegs = 8 // General register count
)
(
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic wrEn, // General register write
  input wire logic [2:0] wrIdx, // Written register
  input wire view_t wrView, // Written view
  input wire logic [DataWidth-1:0] wrData, // Write data, low aligned
  input wire logic [2:0] rdIdx, // Read register
  input wire view_t rdView, // Read view
  input wire logic spWrEn, // Implicit stack pointer write
  input wire logic [DataWidth-1:0] spWrData, // Stack pointer value
  input wire logic pcLoad, // Program counter load
  input wire logic [PcWidth-1:0] pcLoadVal, // New program counter
  input wire logic excEntry, // Exception sequence start
  input wire logic resetVecLoad, // Reset vector fetched
  input wire logic [PcWidth-1:0] resetVec, // Vector table value
  input wire cc_op_t ccOp, // Condition-code instruction
  input wire logic [CcWidth-1:0] ccImm, // Immediate for it
  input wire logic flagEn, // ALU flag update strobe
  input wire flag_op_t flagOp, // Flag update class
  input wire size_t opSize, // Operand size
  input wire logic [DataWidth-1:0] opA, // First operand
  input wire logic [DataWidth-1:0] opB, // Second operand
  input wire logic [DataWidth-1:0] aluResult, // ALU result
  input wire logic shiftOut, // Bit shifted out
  input wire logic bitAcc, // Bit accumulator value
  input wire logic [DataWidth-1:0] effAddr, // Effective address in
  input wire logic wideAccess, // Word or longword access
  input wire logic shortMode, // 1-Mbyte operating mode
  input wire logic [2:0] bitSel, // Bit number in byte
  input wire logic [7:0] byteOperand, // Byte for bit ops / BCD
  input wire branch_t branchCond, // Branch condition select
  input wire logic irqReq, // Maskable interrupt request
  input wire logic nmiReq, // Non-maskable interrupt request
  output logic [DataWidth-1:0] rdData, // Read data, registered
  output logic [DataWidth-1:0] stackPointer, // Register seven
  output logic [PcWidth-1:0] programCounter, // Program counter
  output logic [PcWidth-1:0] fetchAddr, // Fetch address, LSB zero
  output logic [CcWidth-1:0] conditionCode, // Condition code
  output logic [PcWidth-1:0] busAddr, // Truncated operand address
  output logic branchTaken, // Branch condition result
  output logic intAccept, // Interrupt accepted
  output logic selBit, // Selected bit of byte
  output logic [3:0] bcdUpper, // Upper BCD digit
  output logic [3:0] bcdLower // Lower BCD digit
);
  // ==========================================================
  // Elaboration checks
  if (NumRegs != 8)
  begin : g_bad_count
    $error("Register count must be eight");
  end

  // ==========================================================
  // Storage
  logic [DataWidth-1:0] gpr_q [NumRegs]; // General registers
  logic [DataWidth-1:0] gpr_d [NumRegs]; // Next values
  logic [PcWidth-1:0] pc_q, pc_d; // Program counter
  logic [CcWidth-1:0] cc_q, cc_d; // Condition code
  logic [DataWidth-1:0] rd_q, rd_d; // Read port register
  logic [PcWidth-1:0] addr_q, addr_d; // Operand address
  logic br_q, br_d; // Branch result
  logic irq1_q, irq2_q, nmi1_q, nmi2_q; // Request synchronisers
  logic acc_q, acc_d; // Interrupt accept
  logic bit_q, bit_d; // Selected bit
  logic [7:0] bcd_q, bcd_d; // BCD digits
  logic [3:0] flagNext; // N Z V C from flag unit
  logic halfNext; // Half-carry from flag unit

  // ==========================================================
  // Merge a narrow write into a 32-bit register
  function automatic logic [DataWidth-1:0] mergeView(
    input logic [DataWidth-1:0] old,
    input view_t view,
    input logic [DataWidth-1:0] data
  );
    logic [DataWidth-1:0] res;
    res = old;
    case (view)
      VIEW_LONG: res = data;
      VIEW_EXT: res[31:16] = data[15:0];
      VIEW_LOW16: res[15:0] = data[15:0];
      VIEW_HIGH_BYTE: res[15:8] = data[7:0];
      VIEW_LOW_BYTE: res[7:0] = data[7:0];
      default: res = old;
    endcase
    return res;
  endfunction : mergeView

  // Extract a view, zero extended into the low bits
  function automatic logic [DataWidth-1:0] readView(
    input logic [DataWidth-1:0] val,
    input view_t view
  );
    logic [DataWidth-1:0] res;
    res = '0;
    case (view)
      VIEW_LONG: res = val;
      VIEW_EXT: res[15:0] = val[31:16];
      VIEW_LOW16: res[15:0] = val[15:0];
      VIEW_HIGH_BYTE: res[7:0] = val[15:8];
      VIEW_LOW_BYTE: res[7:0] = val[7:0];
      default: res = '0;
    endcase
    return res;
  endfunction : readView

  // ==========================================================
  // Flag computation
  cpu_flag_unit u_flags (
    .opA(opA),
    .opB(opB),
    .result(aluResult),
    .opSize(opSize),
    .flagOp(flagEn ? flagOp : FLAG_KEEP),
    .shiftOut(shiftOut),
    .bitAcc(bitAcc),
    .flagsIn(cc_q[CcNegBit:CcCarryBit]),
    .halfIn(cc_q[CcHalfBit]),
    .flagsOut(flagNext),
    .halfOut(halfNext)
  );

  // ==========================================================
  // General registers, one slice per register
  for (genvar i = 0; i < NumRegs; i++)
  begin : g_gpr
    always_comb
    begin
      gpr_d[i] = gpr_q[i];
      if (wrEn && (wrIdx == 3'(i)))
        gpr_d[i] = mergeView(gpr_q[i], wrView, wrData);
      // implicit stack write wins on register seven
      if (spWrEn && (i == StackIndex))
        gpr_d[i] = spWrData;
    end
    // No reset: contents undefined until software writes
    always_ff @(posedge ref_clk)
    begin
      gpr_q[i] <= gpr_d[i];
    end
  end

  // ==========================================================
  // Program counter and condition code
  always_comb
  begin
    pc_d = pc_q;
    cc_d = cc_q;
    if (pcLoad)
      pc_d = pcLoadVal;
    // ALU flags first, explicit condition ops override
    cc_d[CcNegBit:CcCarryBit] = flagNext;
    cc_d[CcHalfBit] = halfNext;
    case (ccOp)
      CC_LOAD: cc_d = ccImm;
      CC_AND: cc_d = cc_q & ccImm;
      CC_OR: cc_d = cc_q | ccImm;
      CC_XOR: cc_d = cc_q ^ ccImm;
      default: ;
    endcase
    if (excEntry)
      cc_d[CcMaskBit] = 1'b1;
    if (resetVecLoad)
    begin
      pc_d = resetVec;
      cc_d[CcMaskBit] = 1'b1;
    end
  end

  // Only the mask bit has a reset value
  always_ff @(posedge ref_clk)
  begin
    pc_q <= pc_d;
    cc_q[CcMaskBit-1:0] <= cc_d[CcMaskBit-1:0];
    if (rst)
      cc_q[CcMaskBit] <= 1'b1;
    else
      cc_q[CcMaskBit] <= cc_d[CcMaskBit];
  end

  // ==========================================================
  // Interrupt requests arrive from outside; synchronise
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
      nmi1_q <= 1'b0;
      nmi2_q <= 1'b0;
    end
    else
    begin
      irq1_q <= irqReq;
      irq2_q <= irq1_q;
      nmi1_q <= nmiReq;
      nmi2_q <= nmi1_q;
    end
  end

  // ==========================================================
  // Derived outputs
  always_comb
  begin
    logic n, z, v, c;
    n = cc_q[CcNegBit];
    z = cc_q[CcZeroBit];
    v = cc_q[CcOvfBit];
    c = cc_q[CcCarryBit];
    rd_d = readView(gpr_q[rdIdx], rdView);
    // mask bit gates only maskable requests
    acc_d = nmi2_q || (irq2_q && !cc_q[CcMaskBit]);
    addr_d = effAddr[PcWidth-1:0];
    if (shortMode)
      addr_d[PcWidth-1:ShortAddrWidth] = '0;
    if (wideAccess)
      addr_d[0] = 1'b0;
    bit_d = byteOperand[bitSel];
    bcd_d = byteOperand;
    // branch conditions from N Z V C
    case (branchCond)
      BR_ALWAYS: br_d = 1'b1;
      BR_NEVER: br_d = 1'b0;
      BR_HI: br_d = !(c || z);
      BR_LS: br_d = c || z;
      BR_CC: br_d = !c;
      BR_CS: br_d = c;
      BR_NE: br_d = !z;
      BR_EQ: br_d = z;
      BR_VC: br_d = !v;
      BR_VS: br_d = v;
      BR_PL: br_d = !n;
      BR_MI: br_d = n;
      BR_GE: br_d = !(n ^ v);
      BR_LT: br_d = n ^ v;
      BR_GT: br_d = !(z || (n ^ v));
      default: br_d = z || (n ^ v);
    endcase
  end

  // Registered outputs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_q <= '0;
      addr_q <= '0;
      br_q <= 1'b0;
      acc_q <= 1'b0;
      bit_q <= 1'b0;
      bcd_q <= 8'h00;
    end
    else
    begin
      rd_q <= rd_d;
      addr_q <= addr_d;
      br_q <= br_d;
      acc_q <= acc_d;
      bit_q <= bit_d;
      bcd_q <= bcd_d;
    end
  end

  assign rdData = rd_q;
  assign stackPointer = gpr_q[StackIndex];
  assign programCounter = pc_q;
  assign fetchAddr = {pc_q[PcWidth-1:1], 1'b0};
  assign conditionCode = cc_q;
  assign busAddr = addr_q;
  assign branchTaken = br_q;
  assign intAccept = acc_q;
  assign selBit = bit_q;
  assign bcdUpper = bcd_q[7:4];
  assign bcdLower = bcd_q[3:0];
endmodule : cpu_register_file_ccr
`default_nettype wire

// *** tb/cpu_regs_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checks on the register file
module cpu_regs_properties
  import cpu_regs_pkg::*;
#(
  parameter int NumRegs = 8 // Register count
)
(
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic spWrEn, // SP write
  input wire logic [DataWidth-1:0] spWrData, // SP value
  input wire logic pcLoad, // PC load
  input wire logic [PcWidth-1:0] pcLoadVal, // New PC
  input wire logic excEntry, // Exception
  input wire logic resetVecLoad, // Vector load
  input wire logic [PcWidth-1:0] resetVec, // Vector
  input wire cc_op_t ccOp, // CC op
  input wire logic [CcWidth-1:0] ccImm, // CC immediate
  input wire logic [DataWidth-1:0] effAddr, // Address
  input wire logic shortMode, // Short mode
  input wire logic [7:0] byteOperand, // Byte
  input wire logic [2:0] bitSel, // Bit number
  input wire logic nmiReq, // NMI
  input wire logic [DataWidth-1:0] stackPointer, // SP
  input wire logic [PcWidth-1:0] programCounter, // PC
  input wire logic [PcWidth-1:0] fetchAddr, // Fetch
  input wire logic [CcWidth-1:0] conditionCode, // CCR
  input wire logic [PcWidth-1:0] busAddr, // Bus address
  input wire logic intAccept, // Accepted
  input wire logic selBit, // Bit out
  input wire logic [3:0] bcdUpper, // Upper digit
  input wire logic [3:0] bcdLower // Lower digit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Control state
  a_reset_mask: assert property ($past(rst) |-> conditionCode[7])
    else $error("mask bit clear after reset");
  a_exc_mask: assert property (excEntry |=> conditionCode[7])
    else $error("exception left mask clear");
  a_vector_load: assert property (resetVecLoad |=>
    programCounter == $past(resetVec) && conditionCode[7])
    else $error("vector load wrong");
  a_pc_load: assert property (pcLoad && !resetVecLoad |=>
    programCounter == $past(pcLoadVal)) else $error("pc load wrong");
  a_fetch_even: assert property (pcLoad && !resetVecLoad |=>
    fetchAddr == {$past(pcLoadVal[PcWidth-1:1]), 1'b0})
    else $error("fetch address odd");
  a_sp_write: assert property (spWrEn |=>
    stackPointer == $past(spWrData)) else $error("stack pointer wrong");
  a_cc_load: assert property (ccOp == CC_LOAD && !excEntry &&
    !resetVecLoad |=> conditionCode == $past(ccImm))
    else $error("condition load wrong");
  // ==========================================
  // Address, bit and interrupt paths
  a_short_addr: assert property (shortMode |=> busAddr[23:20] == 4'h0 &&
    busAddr[19:1] == $past(effAddr[19:1])) else $error("short address");
  a_bit_pick: assert property (1'b1 |=>
    selBit == $past(byteOperand[bitSel]) &&
    {bcdUpper, bcdLower} == $past(byteOperand)) else $error("bit or digit");
  a_nmi_accept: assert property (nmiReq [*4] |=> intAccept)
    else $error("nmi not accepted");
  a_mask_blocks: assert property ((conditionCode[7] && !nmiReq) [*4]
    |=> !intAccept) else $error("masked interrupt accepted");
  c_exception: cover property (excEntry);
  c_nmi: cover property (nmiReq ##1 intAccept);
  c_short: cover property (shortMode && effAddr[31:20] != 12'h0);
endmodule : cpu_regs_properties
bind cpu_register_file_ccr cpu_regs_properties #(.NumRegs(NumRegs)) props (.*);
`default_nettype wire

// *** tb/exec_alu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Datapath stand-in: add or subtract
module exec_alu_model
  import cpu_regs_pkg::*;
(
  input wire logic [DataWidth-1:0] opA, // First operand
  input wire logic [DataWidth-1:0] opB, // Second operand
  input wire size_t opSize, // Operand size
  input wire logic doSub, // Subtract when high
  output logic [DataWidth-1:0] aluResult // Size-masked result
);
  logic [DataWidth-1:0] raw; // Full-width sum or difference
  // Masked so upper bits never leak into flags
  always_comb
  begin
    raw = doSub ? opA - opB : opA + opB;
    case (opSize)
      SIZE_BYTE: aluResult = {24'h0, raw[7:0]};
      SIZE_WORD: aluResult = {16'h0, raw[15:0]};
      default: aluResult = raw;
    endcase
  end
endmodule : exec_alu_model
`default_nettype wire

// *** tb/cpu_register_file_ccr_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpu_register_file_ccr_tb
  import cpu_regs_pkg::*;
;
  // ==========================================
  // Stimulus and observed signals
  logic ref_clk = 1'b0, rst = 1'b1, wrEn = 1'b0, spWrEn = 1'b0;
  logic pcLoad = 1'b0, excEntry = 1'b0, resetVecLoad = 1'b0, doSub = 1'b0;
  logic flagEn = 1'b0, shiftOut = 1'b0, bitAcc = 1'b0, wideAccess = 1'b0;
  logic shortMode = 1'b0, irqReq = 1'b0, nmiReq = 1'b0;
  logic [2:0] wrIdx = 3'h0, rdIdx = 3'h0, bitSel = 3'h0;
  view_t wrView = VIEW_LONG, rdView = VIEW_LONG;
  logic [31:0] wrData = 32'h0, spWrData = 32'h0, opA = 32'h0, opB = 32'h0;
  logic [31:0] effAddr = 32'h0, aluResult, rdData, stackPointer, tmp;
  logic [23:0] pcLoadVal = 24'h0, resetVec = 24'h0, e;
  logic [23:0] programCounter, fetchAddr, busAddr;
  cc_op_t ccOp = CC_NONE;
  flag_op_t flagOp = FLAG_KEEP;
  size_t opSize = SIZE_BYTE;
  branch_t branchCond = BR_ALWAYS;
  logic [7:0] ccImm = 8'h0, byteOperand = 8'h0, conditionCode, ccm;
  logic branchTaken, intAccept, selBit;
  logic [3:0] bcdUpper, bcdLower;
  logic [31:0] gm [8]; // Register model
  logic [31:0] seed = 32'h00000059; // Random state
  int err_count = 0, compares = 0, cycles = 0;
  cpu_register_file_ccr dut (.*);
  exec_alu_model alu (.*);
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard, far above the run length
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h000000c5 : 32'h0);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] put(input logic [31:0] o, input view_t v,
                                      input logic [31:0] d);
    case (v)
      VIEW_EXT: return {d[15:0], o[15:0]};
      VIEW_LOW16: return {o[31:16], d[15:0]};
      VIEW_HIGH_BYTE: return {o[31:16], d[7:0], o[7:0]};
      VIEW_LOW_BYTE: return {o[31:8], d[7:0]};
      default: return d;
    endcase
  endfunction : put
  function automatic logic [31:0] get(input logic [31:0] o, input view_t v);
    case (v)
      VIEW_EXT: return {16'h0, o[31:16]};
      VIEW_LOW16: return {16'h0, o[15:0]};
      VIEW_HIGH_BYTE: return {24'h0, o[15:8]};
      VIEW_LOW_BYTE: return {24'h0, o[7:0]};
      default: return o;
    endcase
  endfunction : get
  function automatic logic br(input int c, input logic [7:0] f);
    logic n, z, v, cy;
    {n, z, v, cy} = f[3:0];
    case (c)
      0: return 1'b1;
      1: return 1'b0;
      2: return !(cy | z);
      3: return cy | z;
      4: return !cy;
      5: return cy;
      6: return !z;
      7: return z;
      8: return !v;
      9: return v;
      10: return !n;
      11: return n;
      12: return n ~^ v;
      13: return n ^ v;
      14: return !z & (n ~^ v);
      default: return z | (n ^ v);
    endcase
  endfunction : br
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask : chk_flag
  // Drop strobes after one capture edge
  task automatic settle();
    @(posedge ref_clk);
    wrEn <= 1'b0;
    spWrEn <= 1'b0;
    pcLoad <= 1'b0;
    excEntry <= 1'b0;
    resetVecLoad <= 1'b0;
    ccOp <= CC_NONE;
    flagEn <= 1'b0;
    @(negedge ref_clk);
  endtask : settle
  task automatic wait_out();
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wait_out
  task automatic cc_do(input cc_op_t op, input logic [7:0] v);
    @(posedge ref_clk);
    ccOp <= op;
    ccImm <= v;
    settle();
    case (op)
      CC_AND: ccm = ccm & v;
      CC_OR: ccm = ccm | v;
      CC_XOR: ccm = ccm ^ v;
      default: ccm = v;
    endcase
  endtask : cc_do
  task automatic rd(input int i, input view_t v);
    @(posedge ref_clk);
    rdIdx <= i[2:0];
    rdView <= v;
    wait_out();
    chk_val(rdData, get(gm[i], v));
  endtask : rd
  // Add or subtract with flags from integer arithmetic
  task automatic arith(input size_t s, input logic sub);
    int w, hb;
    logic [32:0] r, hr;
    logic [31:0] a, b, m, hm;
    logic sa;
    w = s == SIZE_BYTE ? 8 : s == SIZE_WORD ? 16 : 32;
    hb = w - 4;
    m = w == 32 ? 32'hffffffff : (32'h1 << w) - 32'h1;
    hm = (32'h1 << hb) - 32'h1;
    a = rnd() & m;
    b = rnd() & m;
    r = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    hr = sub ? {1'b0, a & hm} - {1'b0, b & hm} : {1'b0, a & hm} + {1'b0, b & hm};
    sa = a[w-1];
    @(posedge ref_clk);
    flagEn <= 1'b1;
    flagOp <= sub ? FLAG_SUB : FLAG_ADD;
    opSize <= s;
    opA <= a;
    opB <= b;
    doSub <= sub;
    settle();
    ccm[5] = hr[hb];
    ccm[3:0] = {r[w-1], (r[31:0] & m) == 32'h0,
                (sub ? sa != b[w-1] : sa == b[w-1]) && r[w-1] != sa, r[w]};
    chk_val(conditionCode, ccm);
  endtask : arith
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Test sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk_flag(conditionCode[CcMaskBit], 1'b1);
    tmp = rnd();
    @(posedge ref_clk);
    spWrEn <= 1'b1;
    spWrData <= tmp;
    settle();
    chk_val(stackPointer, tmp);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
      gm[i] = tmp;
    for (int k = 0; k < 5; k++)
      for (int i = 0; i < 8; i++)
      begin
        tmp = rnd();
        @(posedge ref_clk);
        wrEn <= 1'b1;
        wrIdx <= i[2:0];
        wrView <= view_t'(k);
        wrData <= tmp;
        settle();
        gm[i] = put(gm[i], view_t'(k), tmp);
        rd(i, VIEW_LONG);
        rd(i, view_t'(k));
      end
    chk_val(stackPointer, gm[7]);
    $display("test views done");
    for (int k = 0; k < 12; k++)
    begin
      cc_do(cc_op_t'(k % 4 + 1), 8'(rnd()));
      chk_val(conditionCode, ccm);
    end
    @(posedge ref_clk);
    excEntry <= 1'b1;
    settle();
    chk_flag(conditionCode[CcMaskBit], 1'b1);
    $display("test condition ops done");
    cc_do(CC_LOAD, 8'h50);
    for (int k = 0; k < 24; k++)
      arith(size_t'(k % 3), k[2]);
    @(posedge ref_clk);
    flagEn <= 1'b1;
    flagOp <= FLAG_SHIFT;
    shiftOut <= ~ccm[0];
    settle();
    ccm[1:0] = {1'b0, ~ccm[0]};
    chk_val(conditionCode, ccm);
    @(posedge ref_clk);
    flagEn <= 1'b1;
    flagOp <= FLAG_BITACC;
    bitAcc <= ~ccm[0];
    settle();
    ccm[0] = ~ccm[0];
    chk_val(conditionCode, ccm);
    @(posedge ref_clk);
    flagEn <= 1'b1;
    flagOp <= FLAG_LOGIC;
    opSize <= SIZE_LONG;
    opA <= 32'h0;
    opB <= 32'h0;
    doSub <= 1'b0;
    settle();
    ccm[3:1] = 3'h2;
    chk_val(conditionCode, ccm);
    @(posedge ref_clk);
    flagEn <= 1'b1;
    flagOp <= FLAG_KEEP;
    settle();
    chk_val(conditionCode, ccm);
    $display("test flags done");
    for (int p = 0; p < 16; p++)
    begin
      cc_do(CC_LOAD, {4'h0, p[3:0]});
      for (int c = 0; c < 16; c++)
      begin
        @(posedge ref_clk);
        branchCond <= branch_t'(c);
        wait_out();
        chk_flag(branchTaken, br(c, ccm));
      end
    end
    $display("test branches done");
    for (int k = 0; k < 4; k++)
    begin
      tmp = rnd();
      @(posedge ref_clk);
      pcLoad <= 1'b1;
      pcLoadVal <= tmp[23:0];
      settle();
      chk_val({8'h0, programCounter}, {8'h0, tmp[23:0]});
      chk_val({8'h0, fetchAddr}, {8'h0, tmp[23:1], 1'b0});
    end
    cc_do(CC_LOAD, 8'h00);
    @(posedge ref_clk);
    resetVecLoad <= 1'b1;
    resetVec <= tmp[31:8];
    pcLoad <= 1'b1;
    settle();
    chk_val({8'h0, programCounter}, {8'h0, tmp[31:8]});
    chk_flag(conditionCode[CcMaskBit], 1'b1);
    $display("test program counter done");
    for (int k = 0; k < 16; k++)
    begin
      tmp = rnd();
      @(posedge ref_clk);
      effAddr <= tmp;
      shortMode <= k[0];
      wideAccess <= k[1];
      byteOperand <= tmp[7:0];
      bitSel <= k[2:0];
      wait_out();
      e = tmp[23:0];
      if (k[0])
        e[23:20] = 4'h0;
      if (k[1])
        e[0] = 1'b0;
      chk_val({8'h0, busAddr}, {8'h0, e});
      chk_flag(selBit, tmp[k[2:0]]);
      chk_val({24'h0, bcdUpper, bcdLower}, {24'h0, tmp[7:0]});
    end
    $display("test address and bits done");
    cc_do(CC_LOAD, 8'h80);
    @(posedge ref_clk) irqReq <= 1'b1;
    repeat (6) wait_out();
    chk_flag(intAccept, 1'b0);
    @(posedge ref_clk) nmiReq <= 1'b1;
    repeat (6) wait_out();
    chk_flag(intAccept, 1'b1);
    @(posedge ref_clk) nmiReq <= 1'b0;
    cc_do(CC_LOAD, 8'h00);
    repeat (6) wait_out();
    chk_flag(intAccept, 1'b1);
    $display("test interrupts done");
    tally_and_finish();
  end
endmodule : cpu_register_file_ccr_tb
`default_nettype wire
